//--- hdl/tal_alert_logic.v
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`include "tal_regs.vh"

// Operation
// [R01] Each conversion end compares readings to high, low, critical limits, sets status.
// [R02] With mask clear, any alarm bit except busy and diode fault pulls event low.
// [R03] Comparator mode: event releases by itself once the condition is gone.
// [R04] Comparator mode only while comparator bit is one; zero after reset.
// [R05] Interrupt mode: status read with any alarm bit set sets the mask bit.
// [R06] Status bits clear only on status read; next conversion sets them again.
// [R07] Comparator bit zero selects interrupt mode; that is the reset value.
// [R08] Host reads status then writes mask back to zero to re-enable event.
// [R09] Host issues start, response address read, takes byte, no-ack, stop.
// [R10] While event low, acknowledge response read and send own address, arbitrating.
// [R11] After full address sent, release event output and set the mask bit.
// [R12] Alert response address is 0001100; no device owns it.
// [R13] Answer response address only while alert configuration bit is zero.
// [R14] Mask bit disables event output; mask and alert config reset to zero.
// [R15] Critical output active while critical flag set; set above critical limit.
// [R16] Critical flag clears at or below limit minus hysteresis, 1 degree resolution.
// [R17] Critical limit keeps its default and ignores writes until unlock bit set.
// [R18] Format select chooses signed or unsigned limit; range +255 to -256. The 8-bit limit here spans -128 to +127 signed, 0 to +255 unsigned.
// [R19] Never drive the link clock, never stretch it; data line is two-way.
// [R20] Fixed 7-bit own address 1001100, not changeable.
// [R21] Temperatures read as left-justified 16-bit words, unused low bits zero.
// [R22] Temperatures saturate at full scale instead of wrapping.
// [R23] Remote values are 11-bit signed or unsigned words in eighths of a degree.
// [R24] Event and critical outputs are active-low open-drain, released when idle.
module tal_alert_logic #(
  parameter ADDR_W = 8,
  parameter [7:0] CRIT_DEFAULT = `TAL_RST_CRIT_STATUS_FLAG
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire conv_done,
  input wire [12:0] remote_temp_raw,
  input wire [9:0] local_temp_raw,
  input wire diode_fault,
  input wire busy,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  output wire alert_out_n,
  output wire alert_oe,
  output wire critical_out_n,
  output wire critical_oe
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_TX = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;

  // Saturate the remote reading into the 11-bit word of the chosen format
  function [10:0] tal_clamp_remote;
    input [12:0] raw;
    input unsigned_format_sel;
    begin
      if (unsigned_format_sel) begin
        if (raw[12])
          tal_clamp_remote = `TAL_R_UMIN;
        else if (raw[11])
          tal_clamp_remote = `TAL_R_UMAX;
        else
          tal_clamp_remote = raw[10:0];
      end else if (!raw[12] && (raw[11] || raw[10])) begin
        tal_clamp_remote = `TAL_R_SMAX;
      end else if (raw[12] && !(raw[11] && raw[10])) begin
        tal_clamp_remote = `TAL_R_SMIN;
      end else begin
        tal_clamp_remote = raw[10:0];
      end
    end
  endfunction

  // Widen an 11-bit word to 12-bit signed according to the format select
  function [11:0] tal_ext;
    input [10:0] v;
    input unsigned_format_sel;
    begin
      tal_ext = {(unsigned_format_sel ? 1'b0 : v[10]), v};
    end
  endfunction

  // Register state
  reg [7:0] status_ff;
  reg [7:0] cond_ff;
  reg crit_flag_ff;
  reg mask_ff;
  reg unlock_ff;
  reg cmp_mode_ff;
  reg alert_cfg_ff;
  reg usf_ff;
  reg [7:0] lhigh_ff;
  reg [10:0] rhigh_ff;
  reg [10:0] rlow_ff;
  reg [7:0] crit_status_flag_ff;
  reg [7:0] chyst_ff;
  reg [10:0] rtemp_ff;
  reg [7:0] ltemp_ff;
  reg alert_oe_ff;

  // Bus slave state
  reg aw_hold_ff;
  reg [ADDR_W-1:0] awaddr_ff;
  reg w_hold_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  // Link state
  reg [2:0] scl_sync_ff;
  reg [2:0] sda_sync_ff;
  reg scl_ff;
  reg sda_ff;
  reg [2:0] lk_state_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg sda_oe_ff;
  reg ara_done_ff;

  // Handshakes and decoded strobes
  wire wr_go = ce && aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire rd_go = ce && s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = ce && !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = ce && !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = ce && !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  wire wr_cfg = wr_go && (awaddr_ff == `TAL_OFS_CONFIG) && wstrb_ff[0];
  wire wr_fc = wr_go && (awaddr_ff == `TAL_OFS_FILTCMP) && wstrb_ff[0];
  wire wr_ec = wr_go && (awaddr_ff == `TAL_OFS_ENHCFG) && wstrb_ff[0];
  wire st_read = rd_go && (s_axi_araddr == `TAL_OFS_STATUS);
  wire [7:0] alarms = status_ff & `TAL_ST_ALARMS;

  // Event request: live conditions in comparator mode, sticky bits otherwise
  wire alert_req = !mask_ff &&
    (cmp_mode_ff ? |(cond_ff & `TAL_ST_ALARMS) : |alarms); // [R02] [R03] [R04] [R07] [R14]
  wire ara_armed = alert_req && !alert_cfg_ff; // [R13]

  // Saturated readings and the conditions they raise
  wire [10:0] rt_now = tal_clamp_remote(remote_temp_raw, usf_ff); // [R22] [R23]
  reg [7:0] lt_now;
  always @* begin
    if (!local_temp_raw[9] && (local_temp_raw[8] || local_temp_raw[7]))
      lt_now = `TAL_L_SMAX;
    else if (local_temp_raw[9] && !(local_temp_raw[8] && local_temp_raw[7]))
      lt_now = `TAL_L_SMIN;
    else
      lt_now = local_temp_raw[7:0]; // [R22]
  end

  wire [11:0] rt_x = tal_ext(rt_now, usf_ff);
  wire [11:0] rh_x = tal_ext(rhigh_ff, usf_ff);
  wire [11:0] rl_x = tal_ext(rlow_ff, usf_ff);
  wire [9:0] rt_deg = {rt_x[11], rt_x[11:3]};
  wire [9:0] lim_deg = {(usf_ff ? 2'b00 : {2{crit_status_flag_ff[7]}}), crit_status_flag_ff}; // [R18]
  wire [9:0] clr_deg = lim_deg - {2'b00, chyst_ff};
  wire crit_above = $signed(rt_deg) > $signed(lim_deg); // [R15]
  wire crit_below = $signed(rt_deg) <= $signed(clr_deg); // [R16]

  reg [7:0] cond_now;
  always @* begin
    cond_now = 8'h00;
    cond_now[`TAL_ST_LHIGH] = $signed(lt_now) > $signed(lhigh_ff);
    cond_now[`TAL_ST_RHIGH] = $signed(rt_x) > $signed(rh_x);
    cond_now[`TAL_ST_RLOW] = $signed(rt_x) < $signed(rl_x);
    cond_now[`TAL_ST_DIODE] = diode_fault;
    cond_now[`TAL_ST_CRIT] = crit_above; // [R01]
  end

  // Conversion results, sticky status and critical flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= 8'h00;
      cond_ff <= 8'h00;
      crit_flag_ff <= 1'b0;
      rtemp_ff <= 11'h000;
      ltemp_ff <= 8'h00;
    end else if (ce) begin
      if (conv_done) begin
        rtemp_ff <= rt_now;
        ltemp_ff <= lt_now;
        cond_ff <= cond_now;
        if (crit_above)
          crit_flag_ff <= 1'b1; // [R15]
        else if (crit_below)
          crit_flag_ff <= 1'b0; // [R16]
      end
      // A conversion landing on the clearing read keeps its bits
      status_ff <= (status_ff & (st_read ? 8'h00 : 8'hFF)) |
        (conv_done ? (cond_now & ~(8'h01 << `TAL_ST_BUSY)) : 8'h00); // [R01] [R06]
    end
  end

  // Control registers written by software, mask also set by hardware
  always @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= 1'b0; // [R14]
      unlock_ff <= 1'b0;
      cmp_mode_ff <= 1'b0; // [R04] [R07]
      alert_cfg_ff <= 1'b0; // [R14]
      usf_ff <= 1'b0;
    end else if (ce) begin
      if (ara_done_ff || (st_read && !cmp_mode_ff && |alarms))
        mask_ff <= 1'b1; // [R05] [R11]
      else if (wr_cfg)
        mask_ff <= wdata_ff[`TAL_CFG_MASK]; // [R08]
      if (wr_cfg)
        unlock_ff <= wdata_ff[`TAL_CFG_UNLOCK];
      if (wr_fc) begin
        cmp_mode_ff <= wdata_ff[`TAL_FC_CMPMODE];
        alert_cfg_ff <= wdata_ff[`TAL_FC_ALERTCFG];
      end
      if (wr_ec)
        usf_ff <= wdata_ff[`TAL_EC_USF]; // [R18]
    end
  end

  // Limit registers; 16-bit limits keep their top 11 bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      lhigh_ff <= `TAL_RST_LHIGH;
      rhigh_ff <= `TAL_RST_RHIGH;
      rlow_ff <= `TAL_RST_RLOW;
      crit_status_flag_ff <= CRIT_DEFAULT;
      chyst_ff <= `TAL_RST_CHYST;
    end else if (wr_go) begin
      case (awaddr_ff)
        `TAL_OFS_LHIGH: begin
          if (wstrb_ff[0])
            lhigh_ff <= wdata_ff[7:0];
        end
        `TAL_OFS_RHIGH: begin
          if (wstrb_ff[1])
            rhigh_ff[10:3] <= wdata_ff[15:8];
          if (wstrb_ff[0])
            rhigh_ff[2:0] <= wdata_ff[7:5]; // [R23]
        end
        `TAL_OFS_RLOW: begin
          if (wstrb_ff[1])
            rlow_ff[10:3] <= wdata_ff[15:8];
          if (wstrb_ff[0])
            rlow_ff[2:0] <= wdata_ff[7:5];
        end
        `TAL_OFS_CRIT_STATUS_FLAG: begin
          if (wstrb_ff[0] && unlock_ff)
            crit_status_flag_ff <= wdata_ff[7:0]; // [R17]
        end
        `TAL_OFS_CHYST: begin
          if (wstrb_ff[0])
            chyst_ff <= wdata_ff[7:0];
        end
        default: begin
          lhigh_ff <= lhigh_ff;
        end
      endcase
    end
  end

  // Read decode; temperatures are left-justified with zero low bits
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TAL_OFS_STATUS: begin
        rd_mux[7:0] = status_ff;
        rd_mux[`TAL_ST_BUSY] = busy;
        rd_mux[`TAL_ST_CRIT] = crit_flag_ff; // [R15]
      end
      `TAL_OFS_CONFIG: begin
        rd_mux[`TAL_CFG_MASK] = mask_ff;
        rd_mux[`TAL_CFG_UNLOCK] = unlock_ff;
      end
      `TAL_OFS_FILTCMP: begin
        rd_mux[`TAL_FC_CMPMODE] = cmp_mode_ff;
        rd_mux[`TAL_FC_ALERTCFG] = alert_cfg_ff;
      end
      `TAL_OFS_ENHCFG: rd_mux[`TAL_EC_USF] = usf_ff;
      `TAL_OFS_LHIGH: rd_mux[7:0] = lhigh_ff;
      `TAL_OFS_RHIGH: rd_mux[15:5] = rhigh_ff;
      `TAL_OFS_RLOW: rd_mux[15:5] = rlow_ff;
      `TAL_OFS_CRIT_STATUS_FLAG: rd_mux[7:0] = crit_status_flag_ff;
      `TAL_OFS_CHYST: rd_mux[7:0] = chyst_ff;
      `TAL_OFS_RTEMP: rd_mux[15:5] = rtemp_ff; // [R21]
      `TAL_OFS_LTEMP: rd_mux[15:8] = ltemp_ff; // [R21]
      default: rd_hit = 1'b0;
    endcase
  end

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= {ADDR_W{1'b0}};
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `TAL_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (awaddr_ff > `TAL_OFS_LTEMP || awaddr_ff[1:0] != 2'h0) ?
          `TAL_RESP_SLVERR : `TAL_RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: one beat, data registered at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `TAL_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? `TAL_RESP_OKAY : `TAL_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Link pins: three stages, a level counts once stages two and three agree
  wire scl_ok = scl_sync_ff[1] == scl_sync_ff[2];
  wire sda_ok = sda_sync_ff[1] == sda_sync_ff[2];
  wire scl_rise = scl_ok && scl_sync_ff[2] && !scl_ff;
  wire scl_fall = scl_ok && !scl_sync_ff[2] && scl_ff;
  wire sda_rise = sda_ok && sda_sync_ff[2] && !sda_ff;
  wire sda_fall = sda_ok && !sda_sync_ff[2] && sda_ff;
  wire [7:0] reply = {`TAL_OWN_ADDR, 1'b0}; // [R20]

  // Alert response: take the address, acknowledge, send own address
  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      lk_state_ff <= ST_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      ara_done_ff <= 1'b0;
    end else if (ce) begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
      if (scl_ok)
        scl_ff <= scl_sync_ff[2];
      if (sda_ok)
        sda_ff <= sda_sync_ff[2];
      ara_done_ff <= 1'b0;
      if (sda_fall && scl_ff && !sda_oe_ff) begin
        lk_state_ff <= ST_ADDR; // Start or repeated start
        bit_cnt_ff <= 3'h0;
      end else if (sda_rise && scl_ff && !sda_oe_ff) begin
        lk_state_ff <= ST_IDLE; // Stop
      end else begin
        case (lk_state_ff)
          ST_ADDR: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_ff};
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              if (bit_cnt_ff == 3'h7)
                lk_state_ff <= ({shift_ff[6:0], sda_ff} == `TAL_ARA_READ && ara_armed) ?
                  ST_ACK : ST_IDLE; // [R10] [R12] [R13]
            end
          end
          ST_ACK: begin
            if (scl_fall && !sda_oe_ff) begin
              sda_oe_ff <= 1'b1; // [R10]
            end else if (scl_fall) begin
              sda_oe_ff <= ~reply[7];
              shift_ff <= {reply[6:0], 1'b0};
              bit_cnt_ff <= 3'h0;
              lk_state_ff <= ST_TX;
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              if (!sda_oe_ff && !sda_ff) begin
                lk_state_ff <= ST_IDLE; // [R10]
              end else if (bit_cnt_ff == 3'h7) begin
                ara_done_ff <= 1'b1; // [R11]
                lk_state_ff <= ST_DONE;
              end
            end else if (scl_fall) begin
              sda_oe_ff <= ~shift_ff[7];
              shift_ff <= {shift_ff[6:0], 1'b0};
            end
          end
          ST_DONE: begin
            if (scl_fall) begin
              sda_oe_ff <= 1'b0;
              lk_state_ff <= ST_IDLE;
            end
          end
          default: begin
            sda_oe_ff <= 1'b0;
            lk_state_ff <= ST_IDLE;
          end
        endcase
      end
      if (lk_state_ff == ST_IDLE || lk_state_ff == ST_ADDR)
        sda_oe_ff <= 1'b0;
    end
  end

  // Event pin follows the request one cycle later
  always @(posedge aclk) begin
    if (!aresetn)
      alert_oe_ff <= 1'b0;
    else if (ce)
      alert_oe_ff <= alert_req && !ara_done_ff; // [R11]
  end

  // Open-drain pins only ever pull low; the clock line has no driver
  assign sda_o = 1'b0; // [R19]
  assign sda_oe = sda_oe_ff; // [R19]
  assign alert_out_n = 1'b0; // [R24]
  assign alert_oe = alert_oe_ff; // [R24]
  assign critical_out_n = 1'b0; // [R24]
  assign critical_oe = crit_flag_ff; // [R15] [R24]

endmodule

//--- hdl/tal_regs.vh
`ifndef TAL_REGS_VH
`define TAL_REGS_VH

// Register byte offsets on the AXI4-Lite bus
`define TAL_OFS_STATUS    8'h00
`define TAL_OFS_CONFIG    8'h04
`define TAL_OFS_FILTCMP   8'h08
`define TAL_OFS_ENHCFG    8'h0C
`define TAL_OFS_LHIGH     8'h10
`define TAL_OFS_RHIGH     8'h14
`define TAL_OFS_RLOW      8'h18
`define TAL_OFS_CRIT_STATUS_FLAG     8'h1C
`define TAL_OFS_CHYST     8'h20
`define TAL_OFS_RTEMP     8'h24
`define TAL_OFS_LTEMP     8'h28

// Alarm status bit positions
`define TAL_ST_BUSY       7
`define TAL_ST_LHIGH      6
`define TAL_ST_RHIGH      4
`define TAL_ST_RLOW       3
`define TAL_ST_DIODE      2
`define TAL_ST_CRIT       1
`define TAL_ST_ALARMS     8'h5A

// Control bit positions
`define TAL_CFG_MASK      7
`define TAL_CFG_UNLOCK    1
`define TAL_FC_CMPMODE    0
`define TAL_FC_ALERTCFG   1
`define TAL_EC_USF        3

// Reset values
`define TAL_RST_LHIGH     8'h46
`define TAL_RST_RHIGH     11'h230
`define TAL_RST_RLOW      11'h000
`define TAL_RST_CRIT_STATUS_FLAG     8'h55
`define TAL_RST_CHYST     8'h0A

// Saturation limits of the temperature words
`define TAL_R_SMAX        11'h3FF
`define TAL_R_SMIN        11'h400
`define TAL_R_UMAX        11'h7FF
`define TAL_R_UMIN        11'h000
`define TAL_L_SMAX        8'h7F
`define TAL_L_SMIN        8'h80

// Link addresses: own address and alert response address, with read bit
`define TAL_OWN_ADDR      7'h4C
`define TAL_ARA_READ      8'h19

// AXI responses
`define TAL_RESP_OKAY     2'h0
`define TAL_RESP_SLVERR   2'h2

`endif

//--- bench/tal_alert_properties.sv
module tal_alert_chk (
  input wire aclk,
  input wire aresetn,
  input wire conv_done,
  input wire s_axi_bvalid,
  input wire s_axi_rvalid,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe,
  input wire alert_out_n,
  input wire alert_oe,
  input wire critical_out_n,
  input wire critical_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [4:0] scl_hi_ff;
  // Counts how long the link clock has stood high
  always @(posedge aclk) begin
    if (!aresetn || !scl_i) scl_hi_ff <= 5'h00;
    else if (scl_hi_ff != 5'h1F) scl_hi_ff <= scl_hi_ff + 5'h01;
  end
  chk_open_drain:
    assert property (!sda_o && !alert_out_n && !critical_out_n) else $error("pin driven high");
  chk_crit_at_conv:
    assert property ($changed(critical_oe) |-> $past(conv_done) || $past(conv_done, 2))
    else $error("critical moved without conversion");
  chk_alert_rise:
    assert property ($rose(alert_oe) |-> $past(conv_done) || $past(conv_done, 2)
      || s_axi_bvalid || $past(s_axi_bvalid)) else $error("event rose without cause");
  chk_alert_fall:
    assert property ($fell(alert_oe) |-> $past(conv_done) || $past(conv_done, 2)
      || $past(s_axi_rvalid) || $past(s_axi_bvalid) || sda_oe || $past(sda_oe))
    else $error("event fell without cause");
  chk_data_in_low:
    assert property ($changed(sda_oe) |-> !scl_i) else $error("data moved with clock high");
  chk_ack_needs_alert:
    assert property ($rose(sda_oe) |-> alert_oe) else $error("answer without event");
  chk_bit_held:
    assert property ($rose(sda_oe) |-> sda_oe [*4]) else $error("driven bit too short");
  chk_idle_release:
    assert property (scl_hi_ff > 5'h0C |-> !sda_oe) else $error("data held on idle bus");
  cov_ack: cover property ($rose(sda_oe));
  cov_crit: cover property ($rose(critical_oe));
  cov_ara: cover property ($fell(alert_oe) && sda_oe);
endmodule

bind tal_alert_logic tal_alert_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .conv_done(conv_done), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .alert_out_n(alert_out_n),
  .alert_oe(alert_oe), .critical_out_n(critical_out_n), .critical_oe(critical_oe));

//--- bench/tal_smbus_host.sv
module tal_smbus_host (
  output logic scl,
  output logic pull_low,
  input wire sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime Q = 31.25;
  // Idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // One bit: data changes mid low phase, sampled mid high phase
  task bit_cyc(input logic drv, output logic seen);
    begin
      #Q;
      pull_low = drv;
      #Q;
      scl = 1'b1;
      #Q;
      seen = sda;
      #Q;
      scl = 1'b0;
    end
  endtask
  // Response frame; pull forces chosen bits low to win arbitration
  task ara(input logic [7:0] a, input logic [7:0] pull, output logic [8:0] got);
    logic s;
    int i;
    begin
      pull_low = 1'b1;
      #(2 * Q);
      scl = 1'b0;
      for (i = 7; i >= 0; i--) bit_cyc(!a[i], s);
      bit_cyc(1'b0, got[8]);
      for (i = 7; i >= 0; i--) bit_cyc(pull[i], got[i]);
      bit_cyc(1'b0, s);
      #Q;
      pull_low = 1'b1;
      #Q;
      scl = 1'b1;
      #(2 * Q);
      pull_low = 1'b0;
    end
  endtask
endmodule

//--- bench/thermal_alert_critical_out_n_logic_tb.sv
`include "tal_regs.vh"
module thermal_alert_critical_out_n_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn = 1'b0, conv_done = 1'b0, diode_fault = 1'b0, busy = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, d;
  logic [12:0] rt = 13'h0;
  logic [9:0] lt = 10'h0;
  logic [8:0] got;
  wire awready, wready, bvalid, arready, rvalid, sda_o, sda_oe;
  wire alert_n, alert_oe, crit_n, crit_oe, scl, host_pull;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire sda = !(sda_oe || host_pull);
  int errors, compares, i;
  logic [12:0] ct [5] = '{13'h380, 13'h387, 13'h388, 13'h338, 13'h330};
  logic [12:0] sr [4] = '{13'h0C8, 13'h050, 13'h280, 13'h0C8};
  logic [9:0] sl [4] = '{10'h050, 10'h019, 10'h019, 10'h019};
  logic [7:0] ss [4] = '{8'h40, 8'h08, 8'h10, 8'h84};
  logic [12:0] tr [7] = '{13'h0C8, 13'h001, 13'h640, 13'h16A0, 13'h640, 13'h960, 13'h1FF8};
  logic [9:0] tl [7] = '{10'h019, 10'h3FF, 10'h0C8, 10'h338, 10'h019, 10'h019, 10'h019};
  logic [15:0] tw [7] = '{16'h1900, 16'h0020, 16'h7FE0, 16'h8000, 16'hC800, 16'hFFE0, 16'h0};
  logic [15:0] tv [7] = '{16'h1900, 16'hFF00, 16'h7F00, 16'h8000, 16'h1900, 16'h1900, 16'h1900};
  logic [7:0] aa [4] = '{8'h18, 8'h19, 8'h19, 8'h19};
  logic [7:0] pp [4] = '{8'h00, 8'h00, 8'h80, 8'h00};
  logic [1:0] fc [4] = '{2'h0, 2'h2, 2'h0, 2'h0};
  logic [8:0] ag [4] = '{9'h1FF, 9'h1FF, 9'h07F, {1'b0, `TAL_OWN_ADDR, 1'b0}};
  tal_alert_logic uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_done(conv_done), .remote_temp_raw(rt), .local_temp_raw(lt),
    .diode_fault(diode_fault), .busy(busy), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .alert_out_n(alert_n), .alert_oe(alert_oe),
    .critical_out_n(crit_n), .critical_oe(crit_oe));
  tal_smbus_host host (.scl(scl), .pull_low(host_pull), .sda(sda));
  // Bench clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares++;
      if (seen !== exp) begin
        errors++;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      if (errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Register write: address and data offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    logic fin;
    int n;
    begin
      fin = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40 && !fin; n++) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          chk("bresp", bresp, er);
          bready <= 1'b0;
          fin = 1'b1;
        end
      end
      if (!fin) chk("bvalid", 1'b0, 1'b1);
      @(posedge aclk);
    end
  endtask
  task rd(input logic [7:0] a, input logic [1:0] er = 2'h0);
    logic fin;
    int n;
    begin
      fin = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40 && !fin; n++) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          d = rdata;
          chk("rresp", rresp, er);
          rready <= 1'b0;
          fin = 1'b1;
        end
      end
      if (!fin) chk("rvalid", 1'b0, 1'b1);
      @(posedge aclk);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    begin
      rd(a);
      chk($sformatf("reg %h", a), d, e);
    end
  endtask
  // One conversion strobe, then time for the outputs to follow
  task conv(input logic [12:0] r, input logic [9:0] l, input logic f = 1'b0);
    begin
      rt <= r;
      lt <= l;
      diode_fault <= f;
      conv_done <= 1'b1;
      @(posedge aclk);
      conv_done <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask
  task clr;
    begin
      rd(`TAL_OFS_STATUS);
      wr(`TAL_OFS_CONFIG, 32'h02);
    end
  endtask
  // Hang guard
  initial begin
    #200000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(`TAL_OFS_CONFIG, 32'h0);
    rdc(`TAL_OFS_FILTCMP, 32'h0);
    rd(8'h2C, `TAL_RESP_SLVERR);
    wr(8'h30, 32'h1, `TAL_RESP_SLVERR);
    wr(`TAL_OFS_CRIT_STATUS_FLAG, 32'h70);
    rdc(`TAL_OFS_CRIT_STATUS_FLAG, `TAL_RST_CRIT_STATUS_FLAG);
    wr(`TAL_OFS_CONFIG, 32'h02);
    wr(`TAL_OFS_CRIT_STATUS_FLAG, 32'h70);
    rdc(`TAL_OFS_CRIT_STATUS_FLAG, 32'h70);
    for (i = 0; i < 5; i++) begin
      conv(ct[i], 10'h019);
      chk("crit", crit_oe, 5'b01100 >> i & 1);
    end
    clr;
    conv(13'h280, 10'h019);
    conv(13'h0C8, 10'h019);
    chk("alert", alert_oe, 1'b1);
    rdc(`TAL_OFS_STATUS, 32'h10);
    chk("alert", alert_oe, 1'b0);
    rdc(`TAL_OFS_CONFIG, 32'h82);
    rdc(`TAL_OFS_STATUS, 32'h0);
    wr(`TAL_OFS_CONFIG, 32'h02);
    wr(`TAL_OFS_FILTCMP, 32'h01);
    conv(13'h280, 10'h019);
    chk("alert", alert_oe, 1'b1);
    wr(`TAL_OFS_CONFIG, 32'h82);
    chk("alert", alert_oe, 1'b0);
    wr(`TAL_OFS_CONFIG, 32'h02);
    chk("alert", alert_oe, 1'b1);
    conv(13'h0C8, 10'h019);
    chk("alert", alert_oe, 1'b0);
    rdc(`TAL_OFS_STATUS, 32'h10);
    rdc(`TAL_OFS_CONFIG, 32'h02);
    wr(`TAL_OFS_FILTCMP, 32'h0);
    wr(`TAL_OFS_RLOW, 32'h1400);
    for (i = 0; i < 4; i++) begin
      busy <= (i == 3);
      conv(sr[i], sl[i], i == 3);
      chk("alert", alert_oe, |(ss[i] & `TAL_ST_ALARMS));
      rdc(`TAL_OFS_STATUS, ss[i]);
      wr(`TAL_OFS_CONFIG, 32'h02);
    end
    busy <= 1'b0;
    wr(`TAL_OFS_CRIT_STATUS_FLAG, 32'h96);
    conv(13'h0C8, 10'h019);
    chk("crit", crit_oe, 1'b1);
    wr(`TAL_OFS_ENHCFG, 32'h08);
    conv(13'h0C8, 10'h019);
    chk("crit", crit_oe, 1'b0);
    conv(13'h500, 10'h019);
    chk("crit", crit_oe, 1'b1);
    for (i = 0; i < 7; i++) begin
      wr(`TAL_OFS_ENHCFG, (i > 3) ? 32'h08 : 32'h0);
      conv(tr[i], tl[i]);
      rdc(`TAL_OFS_RTEMP, tw[i]);
      rdc(`TAL_OFS_LTEMP, tv[i]);
    end
    wr(`TAL_OFS_ENHCFG, 32'h0);
    wr(`TAL_OFS_CRIT_STATUS_FLAG, 32'h70);
    conv(13'h0C8, 10'h019);
    clr;
    conv(13'h280, 10'h019);
    for (i = 0; i < 4; i++) begin
      wr(`TAL_OFS_FILTCMP, fc[i]);
      host.ara(aa[i], pp[i], got);
      repeat (4) @(posedge aclk);
      chk("ara reply", got, ag[i]);
      chk("alert", alert_oe, i < 3);
    end
    rdc(`TAL_OFS_CONFIG, 32'h82);
    print_verdict;
  end
endmodule
